/* File: inc/prc_defs.svh */
`ifndef PRC_DEFS_SVH
`define PRC_DEFS_SVH

// ------------------------------------------------------------
// frame layout, byte indices from start of frame
// ------------------------------------------------------------
`define PRC_IDX_TYPE_UNTAGGED 16'h000D
`define PRC_IDX_TYPE_TAGGED 16'h0011
`define PRC_ETYPE_VLAN 16'h8100
`define PRC_ETYPE_IPV4 16'h0800
`define PRC_ETYPE_IPV6 16'h86DD
`define PRC_ETYPE_PTP_DEFAULT 16'h88F7
`define PRC_IPV4_PROTO_OFS 16'h0009
`define PRC_IPV6_NEXT_OFS 16'h0006
`define PRC_IPV6_HDR_LEN 16'h0028
`define PRC_IP_PROTO_UDP 8'h11
`define PRC_UDP_DPORT_LO_OFS 16'h0003
`define PRC_UDP_HDR_LEN 16'h0008
`define PRC_UDP_PORT_EVENT 16'h013F
`define PRC_UDP_PORT_GENERAL 16'h0140

// ------------------------------------------------------------
// message layout, offsets from first message byte
// ------------------------------------------------------------
`define PRC_MSG_ID_OFS 16'h0000
`define PRC_MSG_VER_OFS 16'h0001
`define PRC_MSG_SRCPORT_HI 16'h001C
`define PRC_MSG_SRCPORT_LO 16'h001D
`define PRC_MSG_SEQ_HI 16'h001E
`define PRC_MSG_SEQ_LO 16'h001F
`define PRC_MSG_CTRL_OFS 16'h0020
`define PRC_VER_1 4'h1
`define PRC_VER_2 4'h2
`define PRC_V1_CTRL_LAST 8'h04

`endif

/* File: inc/prc_pkg.sv */
package prc_pkg;

   // ------------------------------------------------------------
   // configuration and decode types
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      MODE_V1 = 2'b00,
      MODE_V2 = 2'b01,
      MODE_GPTP = 2'b10
   } prc_mode_t;

   typedef enum logic [1:0] {
      ENC_NONE = 2'b00,
      ENC_L2 = 2'b01,
      ENC_IP4 = 2'b10,
      ENC_IP6 = 2'b11
   } prc_encap_t;

   typedef enum logic [7:0] {
      V1_SYNC = 8'h00,
      V1_DELAY_REQ = 8'h01,
      V1_FOLLOW_UP = 8'h02,
      V1_DELAY_RESP = 8'h03,
      V1_MANAGEMENT = 8'h04
   } prc_v1_msg_t;

   typedef enum logic [3:0] {
      V2_SYNC = 4'h0,
      V2_DELAY_REQ = 4'h1,
      V2_PDELAY_REQ = 4'h2,
      V2_PDELAY_RESP = 4'h3,
      V2_FOLLOW_UP = 4'h8,
      V2_DELAY_RESP = 4'h9,
      V2_PDELAY_FUP = 4'hA,
      V2_ANNOUNCE = 4'hB,
      V2_SIGNALLING = 4'hC,
      V2_MANAGEMENT = 4'hD
   } prc_v2_msg_t;

endpackage

/* File: rtl/prc_rx_classifier.sv */
// Overview of operation
// R1: version 1 accepted only over UDP/IPv4
// R2: version 2 over L2, UDP/IPv4, UDP/IPv6
// R3: generalized profile expects only L2 version 2
// R4: recognise frame first, then check version
// R5: UDP ports 319 event, 320 general
// R6: version 1 compares control byte offset 32
// R7: version 2 compares messageId at offset 0
// R8: version from low nibble of byte 1
// R9: source port 28-29, sequence 30-31, shared
// R10: version 1 control codes 0-4, rest reserved
// R11: version 2 ids 0-3 event, 8-D general
// R12: version 2 also stamps path-delay request/response, whatever the configured type
// R13: on match latch time, source, sequence
// R14: L2 timing flag and timestamp taken flag
// R15: offsets start after Ethertype or UDP header
`timescale 1ns/10ps
`include "prc_defs.svh"

module prc_rx_classifier #(
   parameter int TIME_W = 64,
   parameter logic [15:0] PTP_ETYPE = `PRC_ETYPE_PTP_DEFAULT
) (
   // clock and reset
   input wire logic mclk,
   input wire logic rst,
   // receive byte stream
   input wire logic rxValid,
   input wire logic rxSof,
   input wire logic rxEof,
   input wire logic [7:0] rxData,
   // configuration
   input wire prc_pkg::prc_mode_t cfgMode,
   input wire logic [7:0] cfgMsgType,
   input wire logic [TIME_W-1:0] sysTime,
   input wire logic tsUnlock,
   // timestamp holding registers
   output logic tsLocked,
   output logic [TIME_W-1:0] tsTime,
   output logic [15:0] tsSrcPort,
   output logic [15:0] tsSeqId,
   // descriptor indications, one pulse at frame end
   output logic frameDone,
   output logic ptpL2Flag,
   output logic timestamp_taken_flag
);

   // ------------------------------------------------------------
   // parse state
   // ------------------------------------------------------------
   logic [15:0] idx_q, idx_d;
   logic [7:0] prev_q, prev_d;
   logic vlan_q, vlan_d;
   prc_pkg::prc_encap_t encap_q, encap_d;
   logic [15:0] l3Base_q, l3Base_d;
   logic [15:0] udpBase_q, udpBase_d;
   logic udpOk_q, udpOk_d;
   logic msgOn_q, msgOn_d;
   logic [15:0] msgBase_q, msgBase_d;
   logic [3:0] msgId_q, msgId_d;
   logic [3:0] ver_q, ver_d;
   logic [15:0] src_q, src_d;
   logic [15:0] seq_q, seq_d;
   logic [TIME_W-1:0] rxTime_q, rxTime_d;
   logic took_q, took_d;
   logic done_q, done_d;
   logic l2Out_q, l2Out_d;
   logic tsOut_q, tsOut_d;

   logic [15:0] curIdx;
   logic [15:0] typeIdx;
   logic [15:0] rel;
   logic [15:0] pair;
   logic inMsg;
   logic capture;

   function automatic logic at(input logic [15:0] a, input logic [15:0] b);
      at = (a == b);
   endfunction

   // version 2 ids that the decoder knows; 4-7 and E-F are unused
   function automatic logic v2Known(input logic [3:0] id);
      v2Known = (id <= 4'h3) || ((id >= 4'h8) && (id <= 4'hD)); // R11
   endfunction

   assign curIdx = rxSof ? 16'h0000 : idx_q;
   assign typeIdx = vlan_q ? `PRC_IDX_TYPE_TAGGED : `PRC_IDX_TYPE_UNTAGGED;
   assign pair = {prev_q, rxData};
   assign inMsg = msgOn_q && (curIdx >= msgBase_q);
   assign rel = curIdx - msgBase_q; // R15

   // ------------------------------------------------------------
   // header walk and message decode
   // ------------------------------------------------------------
   always_comb
   begin
      idx_d = idx_q;
      prev_d = prev_q;
      vlan_d = vlan_q;
      encap_d = encap_q;
      l3Base_d = l3Base_q;
      udpBase_d = udpBase_q;
      udpOk_d = udpOk_q;
      msgOn_d = msgOn_q;
      msgBase_d = msgBase_q;
      msgId_d = msgId_q;
      ver_d = ver_q;
      src_d = src_q;
      seq_d = seq_q;
      rxTime_d = rxTime_q;
      took_d = took_q;
      capture = 1'b0;
      done_d = 1'b0;
      l2Out_d = 1'b0;
      tsOut_d = 1'b0;
      if (rxValid)
      begin
         if (rxSof)
         begin
            // time is caught at the first byte; later fields cannot shift it
            rxTime_d = sysTime;
            vlan_d = 1'b0;
            encap_d = prc_pkg::ENC_NONE;
            udpOk_d = 1'b0;
            msgOn_d = 1'b0;
            took_d = 1'b0;
         end
         prev_d = rxData;
         if (curIdx != 16'hFFFF)
            idx_d = curIdx + 16'h0001;
         // a tag moves the type field; only one tag is skipped
         if (at(curIdx, typeIdx) && !msgOn_q && encap_q == prc_pkg::ENC_NONE)
         begin
            if (pair == `PRC_ETYPE_VLAN && !vlan_q)
               vlan_d = 1'b1; // R15
            else if (pair == PTP_ETYPE)
            begin
               encap_d = prc_pkg::ENC_L2;
               msgOn_d = 1'b1; // R4
               msgBase_d = curIdx + 16'h0001; // R15
            end
            else if (pair == `PRC_ETYPE_IPV4)
            begin
               encap_d = prc_pkg::ENC_IP4;
               l3Base_d = curIdx + 16'h0001;
            end
            else if (pair == `PRC_ETYPE_IPV6)
            begin
               encap_d = prc_pkg::ENC_IP6;
               l3Base_d = curIdx + 16'h0001;
               udpBase_d = curIdx + 16'h0001 + `PRC_IPV6_HDR_LEN;
            end
         end
         if (encap_q == prc_pkg::ENC_IP4 && at(curIdx, l3Base_q))
            udpBase_d = l3Base_q + {10'h000, rxData[3:0], 2'b00};
         if (encap_q == prc_pkg::ENC_IP4 && at(curIdx, l3Base_q + `PRC_IPV4_PROTO_OFS))
            udpOk_d = (rxData == `PRC_IP_PROTO_UDP);
         // extension headers are not walked; such frames are not classified
         if (encap_q == prc_pkg::ENC_IP6 && at(curIdx, l3Base_q + `PRC_IPV6_NEXT_OFS))
            udpOk_d = (rxData == `PRC_IP_PROTO_UDP);
         if (udpOk_q && !msgOn_q && at(curIdx, udpBase_q + `PRC_UDP_DPORT_LO_OFS))
         begin
            if (pair == `PRC_UDP_PORT_EVENT || pair == `PRC_UDP_PORT_GENERAL) // R5
            begin
               msgOn_d = 1'b1; // R4
               msgBase_d = udpBase_q + `PRC_UDP_HDR_LEN; // R15
            end
         end
         if (inMsg)
         begin
            if (at(rel, `PRC_MSG_ID_OFS))
               msgId_d = rxData[3:0]; // R7
            if (at(rel, `PRC_MSG_VER_OFS))
               ver_d = rxData[3:0]; // R8
            if (at(rel, `PRC_MSG_SRCPORT_HI))
               src_d[15:8] = rxData; // R9
            if (at(rel, `PRC_MSG_SRCPORT_LO))
               src_d[7:0] = rxData; // R9
            if (at(rel, `PRC_MSG_SEQ_HI))
               seq_d[15:8] = rxData; // R9
            if (at(rel, `PRC_MSG_SEQ_LO))
               seq_d[7:0] = rxData; // R9
            if (at(rel, `PRC_MSG_CTRL_OFS) && !tsLocked)
            begin
               if (ver_q == `PRC_VER_1)
               begin
                  // reserved control codes never match
                  capture = (cfgMode == prc_pkg::MODE_V1) // R6
                     && (encap_q == prc_pkg::ENC_IP4) // R1
                     && (rxData <= `PRC_V1_CTRL_LAST) // R10
                     && (rxData == cfgMsgType); // R6
               end
               else if (ver_q == `PRC_VER_2)
               begin
                  capture = ((cfgMode == prc_pkg::MODE_V2) // R2
                        || (cfgMode == prc_pkg::MODE_GPTP
                           && encap_q == prc_pkg::ENC_L2)) // R3
                     && v2Known(msgId_q)
                     && ((msgId_q == cfgMsgType[3:0]) // R7
                        || msgId_q == prc_pkg::V2_PDELAY_REQ // R12
                        || msgId_q == prc_pkg::V2_PDELAY_RESP); // R12
               end
            end
         end
         if (capture)
            took_d = 1'b1;
         if (rxEof)
         begin
            done_d = 1'b1;
            l2Out_d = (encap_q == prc_pkg::ENC_L2) && msgOn_q; // R14
            tsOut_d = took_q || capture; // R14
            msgOn_d = 1'b0;
            encap_d = prc_pkg::ENC_NONE;
         end
      end
   end

   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         idx_q <= 16'h0000;
         prev_q <= 8'h00;
         vlan_q <= 1'b0;
         encap_q <= prc_pkg::ENC_NONE;
         l3Base_q <= 16'h0000;
         udpBase_q <= 16'h0000;
         udpOk_q <= 1'b0;
         msgOn_q <= 1'b0;
         msgBase_q <= 16'h0000;
         msgId_q <= 4'h0;
         ver_q <= 4'h0;
         src_q <= 16'h0000;
         seq_q <= 16'h0000;
         rxTime_q <= '0;
         took_q <= 1'b0;
         done_q <= 1'b0;
         l2Out_q <= 1'b0;
         tsOut_q <= 1'b0;
      end
      else
      begin
         idx_q <= idx_d;
         prev_q <= prev_d;
         vlan_q <= vlan_d;
         encap_q <= encap_d;
         l3Base_q <= l3Base_d;
         udpBase_q <= udpBase_d;
         udpOk_q <= udpOk_d;
         msgOn_q <= msgOn_d;
         msgBase_q <= msgBase_d;
         msgId_q <= msgId_d;
         ver_q <= ver_d;
         src_q <= src_d;
         seq_q <= seq_d;
         rxTime_q <= rxTime_d;
         took_q <= took_d;
         done_q <= done_d;
         l2Out_q <= l2Out_d;
         tsOut_q <= tsOut_d;
      end
   end

   // ------------------------------------------------------------
   // holding registers
   // ------------------------------------------------------------
   // sequence low byte arrives before the control byte, so seq_q is complete here
   prc_ts_hold #(
      .TIME_W(TIME_W)
   ) u_hold (
      .mclk(mclk),
      .rst(rst),
      .capture(capture), // R13
      .capTime(rxTime_q),
      .capSrcPort(src_q),
      .capSeq(seq_q),
      .unlock(tsUnlock),
      .locked(tsLocked),
      .heldTime(tsTime),
      .heldSrcPort(tsSrcPort),
      .heldSeq(tsSeqId)
   );

   assign frameDone = done_q;
   assign ptpL2Flag = l2Out_q;
   assign timestamp_taken_flag = tsOut_q;

endmodule

/* File: rtl/prc_ts_hold.sv */
`timescale 1ns/10ps

module prc_ts_hold #(
   parameter int TIME_W = 64
) (
   // clock and reset
   input wire logic mclk,
   input wire logic rst,
   // capture request
   input wire logic capture,
   input wire logic [TIME_W-1:0] capTime,
   input wire logic [15:0] capSrcPort,
   input wire logic [15:0] capSeq,
   // software release
   input wire logic unlock,
   // held values
   output logic locked,
   output logic [TIME_W-1:0] heldTime,
   output logic [15:0] heldSrcPort,
   output logic [15:0] heldSeq
);

   logic locked_q, locked_d;
   logic [TIME_W-1:0] time_q, time_d;
   logic [15:0] src_q, src_d;
   logic [15:0] seq_q, seq_d;

   // ------------------------------------------------------------
   // holding registers stay frozen until released
   // ------------------------------------------------------------
   always_comb
   begin
      time_d = time_q;
      src_d = src_q;
      seq_d = seq_q;
      locked_d = locked_q;
      if (unlock)
         locked_d = 1'b0;
      // a capture arriving with the release wins: set beats clear
      if (capture && (!locked_q || unlock))
      begin
         time_d = capTime; // R13
         src_d = capSrcPort; // R13
         seq_d = capSeq; // R13
         locked_d = 1'b1;
      end
   end

   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         locked_q <= 1'b0;
         time_q <= '0;
         src_q <= 16'h0000;
         seq_q <= 16'h0000;
      end
      else
      begin
         locked_q <= locked_d;
         time_q <= time_d;
         src_q <= src_d;
         seq_q <= seq_d;
      end
   end

   assign locked = locked_q;
   assign heldTime = time_q;
   assign heldSrcPort = src_q;
   assign heldSeq = seq_q;

endmodule

/* File: testbench/prc_frame_src.sv */
`timescale 1ns/10ps

module prc_frame_src (
   // clock
   input wire logic mclk,
   // byte stream
   output logic rxValid,
   output logic rxSof,
   output logic rxEof,
   output logic [7:0] rxData
);
   logic [7:0] fq[$];
   logic slow;

   initial
   begin
      rxValid = 1'b0;
      rxSof = 1'b0;
      rxEof = 1'b0;
      rxData = 8'hA5;
      slow = 1'b0;
   end

   // slow mode leaves a gap before every odd byte; idle data flips so stale bytes never match
   task automatic send();
      int i;
      for (i = 0; i < fq.size(); i++)
      begin
         if (slow && i[0])
         begin
            @(negedge mclk);
            rxValid = 1'b0;
            rxData = ~rxData;
         end
         @(negedge mclk);
         rxValid = 1'b1;
         rxSof = (i == 0);
         rxEof = (i == fq.size() - 1);
         rxData = fq[i];
      end
      @(negedge mclk);
      rxValid = 1'b0;
      rxSof = 1'b0;
      rxEof = 1'b0;
      rxData = ~rxData;
   endtask
endmodule

/* File: testbench/prc_rx_classifier_checker.sv */
`timescale 1ns/10ps

module prc_rx_classifier_checker #(
   parameter int TIME_W = 64
) (
   // clock and reset
   input wire logic mclk,
   input wire logic rst,
   // stream and configuration
   input wire logic rxValid,
   input wire logic rxSof,
   input wire logic rxEof,
   input wire logic [7:0] rxData,
   input wire prc_pkg::prc_mode_t cfgMode,
   input wire logic [7:0] cfgMsgType,
   input wire logic [TIME_W-1:0] sysTime,
   input wire logic tsUnlock,
   // results
   input wire logic tsLocked,
   input wire logic [TIME_W-1:0] tsTime,
   input wire logic [15:0] tsSrcPort,
   input wire logic [15:0] tsSeqId,
   input wire logic frameDone,
   input wire logic ptpL2Flag,
   input wire logic timestamp_taken_flag
);
   // ----------
   // byte count
   // ----------
   logic [15:0] idx_q;
   logic [15:0] idx_d;

   always_comb
   begin
      idx_d = idx_q;
      if (rxValid)
         idx_d = rxSof ? 16'h0001 : idx_q + 16'h0001;
   end

   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
         idx_q <= 16'h0000;
      else
         idx_q <= idx_d;
   end

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (rst);

   // ----------
   // properties
   // ----------
   a_done_after_eof: assert property (rxValid && rxEof |=> frameDone)
      else $error("no frame end pulse");
   a_done_cause: assert property (frameDone |-> $past(rxValid && rxEof))
      else $error("stray frame end pulse");
   a_l2_with_done: assert property (ptpL2Flag |-> frameDone)
      else $error("l2 flag outside frame end");
   a_taken_with_done: assert property (timestamp_taken_flag |-> frameDone)
      else $error("taken flag outside frame end");
   a_held_stable: assert property (tsLocked && !tsUnlock |=>
      tsLocked && $stable(tsTime) && $stable(tsSeqId) && $stable(tsSrcPort))
      else $error("held values changed while locked");
   // a capture needs a byte and wins over the release, so only idle releases must clear
   a_unlock_clears: assert property (tsLocked && tsUnlock && !rxValid |=> !tsLocked)
      else $error("unlock ignored");
   a_lock_on_byte: assert property ($rose(tsLocked) |-> $past(rxValid))
      else $error("capture without a byte");
   a_lock_offset: assert property ($rose(tsLocked) |-> idx_q >= 16'h002F)
      else $error("capture before control byte");

   c_taken: cover property (timestamp_taken_flag);
   c_l2_only: cover property (ptpL2Flag && !timestamp_taken_flag);
   c_unlock: cover property (tsLocked && tsUnlock);
endmodule

bind prc_rx_classifier prc_rx_classifier_checker #(.TIME_W(TIME_W)) chk (
   .mclk(mclk), .rst(rst), .rxValid(rxValid), .rxSof(rxSof), .rxEof(rxEof),
   .rxData(rxData), .cfgMode(cfgMode), .cfgMsgType(cfgMsgType), .sysTime(sysTime),
   .tsUnlock(tsUnlock), .tsLocked(tsLocked), .tsTime(tsTime), .tsSrcPort(tsSrcPort),
   .tsSeqId(tsSeqId), .frameDone(frameDone), .ptpL2Flag(ptpL2Flag),
   .timestamp_taken_flag(timestamp_taken_flag));

/* File: testbench/testbench.sv */
`timescale 1ns/10ps

module testbench;
   logic mclk;
   logic rst;
   logic rxValid;
   logic rxSof;
   logic rxEof;
   logic [7:0] rxData;
   prc_pkg::prc_mode_t cfgMode;
   logic [7:0] cfgMsgType;
   logic [63:0] sysTime;
   logic tsUnlock;
   logic tsLocked;
   logic [63:0] tsTime;
   logic [15:0] tsSrcPort;
   logic [15:0] tsSeqId;
   logic frameDone;
   logic ptpL2Flag;
   logic timestamp_taken_flag;
   int err_total;
   int checks;
   int cyc;
   int k;

   prc_frame_src SRC (.mclk(mclk), .rxValid(rxValid), .rxSof(rxSof), .rxEof(rxEof),
      .rxData(rxData));

   prc_rx_classifier DUT (.mclk(mclk), .rst(rst), .rxValid(rxValid), .rxSof(rxSof),
      .rxEof(rxEof), .rxData(rxData), .cfgMode(cfgMode), .cfgMsgType(cfgMsgType),
      .sysTime(sysTime), .tsUnlock(tsUnlock), .tsLocked(tsLocked), .tsTime(tsTime),
      .tsSrcPort(tsSrcPort), .tsSeqId(tsSeqId), .frameDone(frameDone),
      .ptpL2Flag(ptpL2Flag), .timestamp_taken_flag(timestamp_taken_flag));

   initial
   begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end

   // ---------
   // utilities
   // ---------
   task results();
      if (err_total == 0 && checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   task chk(string n, logic [63:0] e, logic [63:0] s);
      checks++;
      if (s !== e)
      begin
         err_total++;
         $display("BAD %s exp %h got %h", n, e, s);
      end
   endtask

   // enc 0 layer 2, 1 udp over ipv4, 2 udp over ipv6
   task mk(int enc, logic [7:0] b0, logic [3:0] ver, logic [7:0] ctl, logic [15:0] port,
      logic tag, logic [15:0] seq);
      int i;
      SRC.fq.delete();
      for (i = 0; i < 12; i++)
         SRC.fq.push_back(8'h20 + i[7:0]);
      if (tag)
         SRC.fq = {SRC.fq, 8'h81, 8'h00, 8'h00, 8'h05};
      if (enc == 0)
         SRC.fq = {SRC.fq, 8'h88, 8'hF7};
      else if (enc == 1)
         SRC.fq = {SRC.fq, 8'h08, 8'h00, 8'h45, 8'h00, 8'h00, 8'h4A, 8'h00, 8'h00, 8'h00,
            8'h00, 8'h40, 8'h11, 8'h00, 8'h00, 8'h0A, 8'h00, 8'h00, 8'h01, 8'h0A, 8'h00,
            8'h00, 8'h02};
      else
      begin
         SRC.fq = {SRC.fq, 8'h86, 8'hDD, 8'h60, 8'h00, 8'h00, 8'h00, 8'h00, 8'h2A, 8'h11,
            8'h40};
         for (i = 0; i < 32; i++)
            SRC.fq.push_back(8'hFE);
      end
      if (enc != 0)
         SRC.fq = {SRC.fq, 8'h04, 8'h00, port[15:8], port[7:0], 8'h00, 8'h2A, 8'h00, 8'h00};
      for (i = 0; i < 36; i++)
         SRC.fq.push_back(i == 0 ? b0 : i == 1 ? {4'h0, ver} : i == 28 ? 8'hC1 :
            i == 29 ? 8'h52 : i == 30 ? seq[15:8] : i == 31 ? seq[7:0] : i == 32 ? ctl : 8'h00);
   endtask

   task unlock();
      tsUnlock = 1'b1;
      @(negedge mclk);
      tsUnlock = 1'b0;
      chk("unlocked", 64'h0, {63'h0, tsLocked});
   endtask

   task run(logic exT, logic exL2, logic keep);
      int n;
      int m;
      sysTime = sysTime + 64'h0000_0101_0000_1111;
      SRC.send();
      n = 0;
      while (frameDone !== 1'b1 && n < 20)
      begin
         @(negedge mclk);
         n++;
      end
      m = SRC.fq.size();
      chk("done", 64'h1, {63'h0, frameDone});
      chk("l2flag", {63'h0, exL2}, {63'h0, ptpL2Flag});
      chk("taken", {63'h0, exT}, {63'h0, timestamp_taken_flag});
      if (exT)
      begin
         chk("locked", 64'h1, {63'h0, tsLocked});
         chk("time", sysTime, tsTime);
         chk("srcport", 64'hC152, {48'h0, tsSrcPort});
         chk("seq", {48'h0, SRC.fq[m - 6], SRC.fq[m - 5]}, {48'h0, tsSeqId});
      end
      if (!keep)
         unlock();
   endtask

   // ---------
   // scenarios
   // ---------
   task t_l2();
      cfgMode = prc_pkg::MODE_V2;
      cfgMsgType = 8'h00;
      mk(0, 8'h00, 4'h2, 8'h00, 16'h0, 1'b0, 16'h0001);
      run(1'b1, 1'b1, 1'b0);
      mk(0, 8'h00, 4'h2, 8'h00, 16'h0, 1'b1, 16'h0002);
      run(1'b1, 1'b1, 1'b0);
      mk(0, 8'h08, 4'h2, 8'h00, 16'h0, 1'b0, 16'h0003);
      run(1'b0, 1'b1, 1'b0);
   endtask

   task t_lock();
      mk(0, 8'h01, 4'h2, 8'h00, 16'h0, 1'b0, 16'h0005);
      cfgMsgType = 8'h01;
      run(1'b1, 1'b1, 1'b1);
      mk(0, 8'h01, 4'h2, 8'h00, 16'h0, 1'b0, 16'h0006);
      run(1'b0, 1'b1, 1'b1);
      chk("heldseq", 64'h5, {48'h0, tsSeqId});
      unlock();
   endtask

   task t_v1();
      cfgMode = prc_pkg::MODE_V1;
      SRC.slow = 1'b1;
      for (k = 0; k < 6; k++)
      begin
         cfgMsgType = k[7:0];
         mk(1, 8'h00, 4'h1, k[7:0], 16'h013F, 1'b0, 16'h0100 + k[15:0]);
         run(k < 5, 1'b0, 1'b0);
      end
      SRC.slow = 1'b0;
      cfgMsgType = 8'h01;
      mk(1, 8'h00, 4'h1, 8'h00, 16'h0140, 1'b0, 16'h0200);
      run(1'b0, 1'b0, 1'b0);
      cfgMsgType = 8'h00;
      mk(0, 8'h00, 4'h1, 8'h00, 16'h0, 1'b0, 16'h0201);
      run(1'b0, 1'b1, 1'b0);
      mk(2, 8'h00, 4'h1, 8'h00, 16'h013F, 1'b0, 16'h0202);
      run(1'b0, 1'b0, 1'b0);
   endtask

   task t_v2_ids();
      cfgMode = prc_pkg::MODE_V2;
      cfgMsgType = 8'h00;
      for (k = 0; k < 16; k++)
      begin
         mk(2, k[7:0], 4'h2, 8'h00, 16'h0140, 1'b0, 16'h0300 + k[15:0]);
         run(k == 0 || k == 2 || k == 3, 1'b0, 1'b0);
      end
      cfgMsgType = 8'h09;
      mk(1, 8'h09, 4'h2, 8'h00, 16'h0140, 1'b0, 16'h0400);
      run(1'b1, 1'b0, 1'b0);
      mk(1, 8'h09, 4'h2, 8'h00, 16'h0141, 1'b0, 16'h0401);
      run(1'b0, 1'b0, 1'b0);
      mk(1, 8'h09, 4'h1, 8'h09, 16'h0140, 1'b0, 16'h0402);
      run(1'b0, 1'b0, 1'b0);
   endtask

   task t_gptp();
      cfgMode = prc_pkg::MODE_GPTP;
      cfgMsgType = 8'h00;
      mk(0, 8'h00, 4'h2, 8'h00, 16'h0, 1'b0, 16'h0500);
      run(1'b1, 1'b1, 1'b0);
      mk(0, 8'h03, 4'h2, 8'h00, 16'h0, 1'b0, 16'h0501);
      run(1'b1, 1'b1, 1'b0);
      mk(1, 8'h00, 4'h2, 8'h00, 16'h013F, 1'b0, 16'h0502);
      run(1'b0, 1'b0, 1'b0);
   endtask

   always @(posedge mclk)
   begin
      cyc++;
      if (cyc > 20000)
      begin
         err_total++;
         results();
      end
   end

   initial
   begin
      err_total = 0;
      checks = 0;
      cyc = 0;
      rst = 1'b1;
      cfgMode = prc_pkg::MODE_V2;
      cfgMsgType = 8'h00;
      sysTime = 64'h0;
      tsUnlock = 1'b0;
      repeat (4) @(negedge mclk);
      rst = 1'b0;
      t_l2();
      t_lock();
      t_v1();
      t_v2_ids();
      t_gptp();
      results();
   end
endmodule
